// file: common/prc_defines.svh
// Purpose: Register offsets, reset values and timing counts of the run controller
// Assumes: 32-bit APB data, one register per aligned word
// Notes: Included by the package and the design files
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH
`define PRC_OFF_CTRL 12'h000
`define PRC_OFF_STATUS 12'h004
`define PRC_OFF_EVENT 12'h008
`define PRC_OFF_MASK 12'h00C
`define PRC_OFF_PC 12'h010
`define PRC_OFF_PLEN 12'h014
`define PRC_CTRL_START 0
`define PRC_CTRL_RESET 1
`define PRC_CTRL_LOADED 2
`define PRC_EV_STOP 0
`define PRC_EV_WAIT 1
`define PRC_EV_TRIG 2
`define PRC_EV_RESET 3
`define PRC_NUM_EV 4
`define PRC_MASK_RST 4'h0
`define PRC_PLEN_RST 8'h10
`define PRC_SYNC_STAGES 3
`endif

// file: common/prc_pkg.sv
// Purpose: Types shared by the run controller files
// Assumes: prc_defines.svh on the include path
// Notes: Holds types only
`include "prc_defines.svh"
package prc_pkg;
  typedef enum logic [1:0] {
    PRC_RESET,
    PRC_RUN,
    PRC_WAIT,
    PRC_STOP
  } prc_state_e;
  typedef enum logic [1:0] {
    PRC_OP_CONT,
    PRC_OP_WAIT,
    PRC_OP_STOP,
    PRC_OP_BRANCH
  } prc_op_e;
endpackage

// file: common/prc_sync_if.sv
// Purpose: Carries one conditioned control input between modules
// Assumes: One clock domain
// Notes: level is active high after inversion of the pin
`timescale 1ns/100ps
`default_nettype none
interface prc_sync_if;
  logic level;
  logic fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface
`default_nettype wire

// file: src/prc_in_sync.sv
// Purpose: Three-stage synchroniser and falling-edge detect of one low-active pin
// Assumes: Pin idles high through a pull-up
// Notes: First stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module prc_in_sync (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Pin and conditioned output
  input wire logic pin_n,
  prc_sync_if.src sync
);
  import prc_pkg::*;
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  // Reset to idle-high so a held pin still gives one edge after release
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      lvl_r <= 1'b1;
    end else begin
      s1_r <= pin_n;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        lvl_r <= s3_r;
      end
    end
  end
  assign sync.level = ~lvl_r;
  assign sync.fall = lvl_r & (s2_r == s3_r) & ~s3_r;
endmodule
`default_nettype wire

// file: src/prc_run_ctrl.sv
// Purpose: Run-state controller of a programmed pulse-sequence engine
// Assumes: Single 250 MHz clock; opcode of the current step arrives from the sequencer
// Notes: APB slave for start, reset, status, events and program length
`timescale 1ns/100ps
`default_nettype none
`include "prc_defines.svh"
module prc_run_ctrl #(
  parameter int PC_W = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // External low-active control pins
  input wire logic EXT_TRIGGER_IN_N,
  input wire logic EXT_RESET_IN_N,
  // Sequencer side
  input wire prc_pkg::prc_op_e OPCODE,
  output logic [PC_W-1:0] PC,
  output logic STEP,
  // Status outputs
  output logic STAT_STOPPED,
  output logic STAT_RESET_N,
  output logic STAT_RUNNING,
  output logic STAT_WAITING,
  // Interrupt
  output logic IRQ
);
  import prc_pkg::*;
  prc_sync_if trg_s ();
  prc_sync_if rst_s ();
  prc_state_e state_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] plen_r;
  logic loaded_r;
  logic [`PRC_NUM_EV-1:0] ev_r;
  logic [`PRC_NUM_EV-1:0] mask_r;
  logic [`PRC_NUM_EV-1:0] ev_set;
  logic [31:0] rdata_nxt;
  logic sw_start;
  logic sw_reset;
  logic wr_acc;
  logic rd_acc;
  logic ext_trigger_in;
  logic hold_rst;
  logic go;
  logic ev_rd;

  // Both pins conditioned identically
  prc_in_sync u_trg (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .pin_n(EXT_TRIGGER_IN_N),
    .sync(trg_s.src)
  );
  prc_in_sync u_rst (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .pin_n(EXT_RESET_IN_N),
    .sync(rst_s.src)
  );

  // Zero-wait APB; every access completes in its access phase
  assign PREADY = 1'b1;
  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign rd_acc = PSEL & PENABLE & ~PWRITE;
  assign PSLVERR = PSEL & PENABLE & ~(PADDR == `PRC_OFF_CTRL || PADDR == `PRC_OFF_STATUS
    || PADDR == `PRC_OFF_EVENT || PADDR == `PRC_OFF_MASK || PADDR == `PRC_OFF_PC
    || PADDR == `PRC_OFF_PLEN);
  assign sw_start = wr_acc & (PADDR == `PRC_OFF_CTRL) & PWDATA[`PRC_CTRL_START];
  assign sw_reset = wr_acc & (PADDR == `PRC_OFF_CTRL) & PWDATA[`PRC_CTRL_RESET];
  assign ev_rd = rd_acc & (PADDR == `PRC_OFF_EVENT);

  // Held low pin counts every cycle, so a level trigger keeps firing
  assign hold_rst = rst_s.level;
  assign ext_trigger_in = trg_s.fall | trg_s.level;
  assign go = (ext_trigger_in | sw_start) & loaded_r & ~hold_rst;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      loaded_r <= 1'b0;
      plen_r <= `PRC_PLEN_RST;
      mask_r <= `PRC_MASK_RST;
    end else if (wr_acc) begin
      if (PADDR == `PRC_OFF_CTRL) begin
        loaded_r <= PWDATA[`PRC_CTRL_LOADED];
      end
      if (PADDR == `PRC_OFF_PLEN) begin
        plen_r <= PWDATA[PC_W-1:0];
      end
      if (PADDR == `PRC_OFF_MASK) begin
        mask_r <= PWDATA[`PRC_NUM_EV-1:0];
      end
    end
  end

  // Run state and program position
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r <= PRC_RESET;
      pc_r <= '0;
    end else if (hold_rst || sw_reset) begin
      state_r <= PRC_RESET;
      pc_r <= '0;
    end else begin
      case (state_r)
        PRC_RESET: begin
          if (go) begin
            state_r <= PRC_RUN;
            pc_r <= '0;
          end
        end
        PRC_RUN: begin
          case (OPCODE)
            PRC_OP_WAIT: state_r <= PRC_WAIT;
            PRC_OP_STOP: state_r <= PRC_STOP;
            PRC_OP_BRANCH: pc_r <= '0;
            default: pc_r <= (pc_r + 1'b1 >= plen_r) ? '0 : PC_W'(pc_r + 1'b1);
          endcase
        end
        PRC_WAIT: begin
          if (go) begin
            state_r <= PRC_RUN;
            pc_r <= (pc_r + 1'b1 >= plen_r) ? '0 : PC_W'(pc_r + 1'b1);
          end
        end
        PRC_STOP: begin
          // Restart from the top on go; no reset is needed first
          if (go) begin
            state_r <= PRC_RUN;
            pc_r <= '0;
          end
        end
        default: state_r <= PRC_RESET;
      endcase
    end
  end

  // Status pins from flops, one cycle after state
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      STAT_STOPPED <= 1'b0;
      STAT_RESET_N <= 1'b0;
      STAT_RUNNING <= 1'b0;
      STAT_WAITING <= 1'b0;
    end else begin
      STAT_STOPPED <= (state_r == PRC_STOP);
      STAT_RESET_N <= (state_r != PRC_RESET);
      STAT_RUNNING <= (state_r == PRC_RUN);
      STAT_WAITING <= (state_r == PRC_WAIT);
    end
  end

  assign PC = pc_r;
  assign STEP = (state_r == PRC_RUN);

  // Sticky events; set wins over read clear
  always_comb begin
    ev_set = '0;
    ev_set[`PRC_EV_STOP] = (state_r == PRC_RUN) & (OPCODE == PRC_OP_STOP);
    ev_set[`PRC_EV_WAIT] = (state_r == PRC_RUN) & (OPCODE == PRC_OP_WAIT);
    ev_set[`PRC_EV_TRIG] = trg_s.fall;
    ev_set[`PRC_EV_RESET] = rst_s.fall;
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ev_r <= '0;
    end else begin
      // Clear only what the read returned, so an event landing on the setup edge is kept
      ev_r <= (ev_r & ~(ev_rd ? PRDATA[`PRC_NUM_EV-1:0] : '0)) | ev_set;
    end
  end
  assign IRQ = |(ev_r & mask_r);

  always_comb begin
    rdata_nxt = '0;
    case (PADDR)
      `PRC_OFF_CTRL: rdata_nxt[`PRC_CTRL_LOADED] = loaded_r;
      `PRC_OFF_STATUS: rdata_nxt[3:0] = {STAT_WAITING, STAT_RUNNING, STAT_RESET_N, STAT_STOPPED};
      `PRC_OFF_EVENT: rdata_nxt[`PRC_NUM_EV-1:0] = ev_r;
      `PRC_OFF_MASK: rdata_nxt[`PRC_NUM_EV-1:0] = mask_r;
      `PRC_OFF_PC: rdata_nxt[PC_W-1:0] = pc_r;
      `PRC_OFF_PLEN: rdata_nxt[PC_W-1:0] = plen_r;
      default: rdata_nxt = '0;
    endcase
  end
  // Read data registered in setup so it is stable in access
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= rdata_nxt;
    end
  end

  chk_reset_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
    hold_rst |=> state_r == PRC_RESET ##1 !STAT_RUNNING)
    else $error("reset input did not hold reset");
  chk_stop_flag: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_r == PRC_RUN && OPCODE == PRC_OP_STOP && !hold_rst && !sw_reset |=> ##1 STAT_STOPPED)
    else $error("stopped not raised");
  chk_reset_low: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_r == PRC_RESET |=> !STAT_RESET_N)
    else $error("reset status not low");
  chk_run_high: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_r == PRC_RUN |=> STAT_RUNNING)
    else $error("running not high");
  chk_idle_low: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_r inside {PRC_RESET, PRC_STOP, PRC_WAIT} |=> !STAT_RUNNING)
    else $error("running high while idle");
  chk_wait_resume: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_r == PRC_WAIT && go && !sw_reset |=>
      state_r == PRC_RUN && pc_r != $past(pc_r) || plen_r == 1)
    else $error("pause did not resume to next step");
  chk_trig_start: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_r inside {PRC_RESET, PRC_STOP} && go && !sw_reset |=> state_r == PRC_RUN && pc_r == '0)
    else $error("trigger did not restart");
  chk_reset_pc: assert property (@(posedge CLK) disable iff (SYS_RST)
    hold_rst |=> pc_r == '0)
    else $error("position not cleared by reset");
  chk_no_load: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_r == PRC_RESET && !loaded_r && !hold_rst |=> state_r == PRC_RESET)
    else $error("started without program");
  cov_run_stop: cover property (@(posedge CLK) disable iff (SYS_RST)
    state_r == PRC_RUN ##[1:50] state_r == PRC_STOP);
  cov_wait_go: cover property (@(posedge CLK) disable iff (SYS_RST)
    state_r == PRC_WAIT ##1 state_r == PRC_RUN);
  cov_ext_rst: cover property (@(posedge CLK) disable iff (SYS_RST) rst_s.fall);
  cov_irq: cover property (@(posedge CLK) disable iff (SYS_RST) IRQ);
endmodule
`default_nettype wire

// file: test/prc_pin_model.sv
// Purpose: Far-side source of the two low-active control pins
// Assumes: Both pins idle high through pull-ups
// Notes: A short pulse request is stretched, never shortened
`timescale 1ns/100ps
`default_nettype none
module prc_pin_model #(
  parameter int MIN_LOW = 13
) (
  // Clock
  input wire logic CLK,
  // Commands from the bench
  input wire logic trig_go,
  input wire logic [7:0] trig_len,
  input wire logic trig_hold,
  input wire logic rst_hold,
  // Pins
  output logic EXT_TRIGGER_IN_N,
  output logic EXT_RESET_IN_N
);
  logic [7:0] low_cnt_r = 8'h00;
  // 13 cycles of 4 ns cover the minimum low time
  always @(posedge CLK) begin
    if (trig_go) begin
      low_cnt_r <= (trig_len < 8'(MIN_LOW)) ? 8'(MIN_LOW) : trig_len;
    end else if (low_cnt_r != 8'h00) begin
      low_cnt_r <= low_cnt_r - 8'h01;
    end
  end
  // Released pins rise through the pull-up, so every pulse starts high
  assign EXT_TRIGGER_IN_N = !(trig_hold || low_cnt_r != 8'h00);
  assign EXT_RESET_IN_N = !rst_hold;
endmodule
`default_nettype wire

// file: test/testbench.sv
// Purpose: Random and corner runs of the run controller
// Assumes: Status vector is stopped, reset_n, running, waiting
// Notes: Status lags the state, so every wait is bounded
`timescale 1ns/100ps
`default_nettype none
`include "prc_defines.svh"
module testbench;
  import prc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, th = 1'b0, rh = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic rdy, serr, err, tn, rn, step, irq, s_stop, s_rstn, s_run, s_wait;
  logic [7:0] pc, tl = 8'h0D;
  prc_op_e op = PRC_OP_CONT;
  int n_errors = 0, n_compared = 0, cyc = 0, plen, p0, k;
  always #2 clk = ~clk; // Square wave
  prc_run_ctrl prc_run_ctrl_i (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr), .EXT_TRIGGER_IN_N(tn), .EXT_RESET_IN_N(rn),
    .OPCODE(op), .PC(pc), .STEP(step), .STAT_STOPPED(s_stop), .STAT_RESET_N(s_rstn), .STAT_RUNNING(s_run),
    .STAT_WAITING(s_wait), .IRQ(irq));
  prc_pin_model prc_pin_model_i (.CLK(clk), .trig_go(go), .trig_len(tl), .trig_hold(th), .rst_hold(rh),
    .EXT_TRIGGER_IN_N(tn), .EXT_RESET_IN_N(rn));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] stat_of(input prc_state_e s);
    case (s)
      PRC_RUN: return 4'h6;
      PRC_WAIT: return 4'h5;
      PRC_STOP: return 4'hC;
      default: return 4'h0;
    endcase
  endfunction
  task automatic wait_stat(input prc_state_e s);
    // Never judge registered status in the time step of the edge that launches it
    @(negedge clk);
    for (int i = 0; i < 12 && {s_stop, s_rstn, s_run, s_wait} !== stat_of(s); i++) @(negedge clk);
    cmp({28'h0, s_stop, s_rstn, s_run, s_wait}, {28'h0, stat_of(s)});
  endtask
  // First running cycle must sit on the first step
  task automatic wait_step();
    for (int i = 0; i < 12 && step !== 1'b1; i++) @(negedge clk);
    cmp({31'h0, step}, 32'h1);
    cmp({24'h0, pc}, 32'h0);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    err = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] len);
    @(posedge clk);
    tl <= len;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic one_op(input prc_op_e o);
    @(posedge clk);
    op <= o;
    @(posedge clk);
    op <= PRC_OP_CONT;
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(20));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wait_stat(PRC_RESET);
    apb(1'b0, `PRC_OFF_MASK, 32'h0);
    cmp(rd, {28'h0, `PRC_MASK_RST});
    apb(1'b0, `PRC_OFF_PLEN, 32'h0);
    cmp(rd, {24'h0, `PRC_PLEN_RST});
    apb(1'b1, 12'h0F0, 32'h5);
    cmp({31'h0, err}, 32'h1);
    // Let the synchronised level clear, or loading would start the program at once
    pulse(8'h10);
    repeat (24) @(negedge clk);
    wait_stat(PRC_RESET);
    for (k = 0; k < 4; k++) begin
      plen = 2 + $urandom % 14;
      apb(1'b1, `PRC_OFF_PLEN, 32'(plen));
      apb(1'b1, `PRC_OFF_CTRL, 32'h6);
      wait_stat(PRC_RESET);
      pulse(8'h0D + 8'($urandom % 8));
      cmp({31'h0, step}, 32'h0);
      wait_step();
      wait_stat(PRC_RUN);
      for (int i = 0; i < 20; i++) begin
        p0 = pc;
        @(negedge clk);
        cmp({24'h0, pc}, 32'((p0 + 1) % plen));
      end
      one_op(PRC_OP_WAIT);
      wait_stat(PRC_WAIT);
      p0 = pc;
      repeat (5) @(negedge clk);
      cmp({24'h0, pc}, 32'(p0));
      // Alternate software and hardware resume
      if (k[0])
        apb(1'b1, `PRC_OFF_CTRL, 32'h5);
      else
        pulse(8'h0D);
      wait_stat(PRC_RUN);
      // Trigger must be gone before the halt, or it restarts at once
      repeat (16) @(negedge clk);
      apb(1'b1, `PRC_OFF_MASK, 32'h1);
      one_op(PRC_OP_STOP);
      wait_stat(PRC_STOP);
      cmp({31'h0, irq}, 32'h1);
      apb(1'b0, `PRC_OFF_EVENT, 32'h0);
      cmp(rd & 32'h1, 32'h1);
      @(negedge clk);
      cmp({31'h0, irq}, 32'h0);
    end
    @(posedge clk);
    rh <= 1'b1;
    wait_stat(PRC_RESET);
    cmp({24'h0, pc}, 32'h0);
    pulse(8'h0D);
    apb(1'b1, `PRC_OFF_CTRL, 32'h5);
    repeat (12) @(negedge clk);
    wait_stat(PRC_RESET);
    @(posedge clk);
    rh <= 1'b0;
    repeat (6) @(posedge clk);
    pulse(8'h0D);
    wait_step();
    @(posedge clk);
    rh <= 1'b1;
    repeat (8) @(posedge clk);
    rh <= 1'b0;
    repeat (6) @(posedge clk);
    apb(1'b1, `PRC_OFF_CTRL, 32'h5);
    wait_step();
    // A held trigger must keep releasing every pause
    @(posedge clk);
    op <= PRC_OP_WAIT;
    th <= 1'b1;
    p0 = 0;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      p0 += step;
    end
    cmp(32'(p0 > 3), 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
